/* File: hw/acs_top.sv */
/*
 * Digital control around a 10-bit successive-approximation converter:
 * input-select register with deferred update, channel and reference
 * decoding, result coding and alignment, and the paired result read.
 * Assumes a plain register port with read data one cycle after the strobe,
 * and an external array driven by dac_code_out returning cmp_in.
 */
// The address-and-strobe port and the register addresses were chosen for this implementation.
// What this block does
// - Single-ended results are unsigned codes, 0x000 at ground up to 0x3FF at reference less one step.
// - Differential results are two's complement, saturating at 0x1FF and reaching 0x200 at minus full reference.
// - The finished result sits in the two result registers once the complete flag is high, unless a low-byte read had frozen them; then it is dropped.
// - The reference field at bits 7:6 picks the external pin, the analog supply or the internal 1.1V source.
// - Reference and channel written during a conversion take effect only when it completes.
// - The alignment bit at 5 picks left or right alignment and changes the readable data at once.
// - The channel field at bits 4:0 picks the input combination and 01000 to 01111 pick nothing.
// - Codes 00000 to 00111 pick single inputs 0 to 7, 11110 the bandgap and 11111 ground.
// - Codes 10000 to 10111 pair inputs 0 to 7 against input 1, and 11000 to 11101 inputs 0 to 5 against 2.
// - The input-select register is eight read-write bits that reset to zero.
// - Right alignment puts bits 9:8 low in the high byte; left puts 9:2 high and 1:0 atop the low byte.
// - After the low byte is read the result stays frozen until the high byte is read.
`timescale 1ns/1ps
`include "acs_consts.svh"
module acs_top #(
    parameter int ADC_DIV = `ACS_ADC_DIV
) (
    input  wire logic                clk_sys_in,
    input  wire logic                rst_n_in,
    input  wire acs_pkg::acs_addr_t  reg_addr_in,
    input  wire acs_pkg::acs_byte_t  reg_wdata_in,
    input  wire logic                reg_wr_in,
    input  wire logic                reg_rd_in,
    output acs_pkg::acs_byte_t       reg_rdata_out,
    input  wire logic                cmp_in,
    output acs_pkg::acs_result_t     dac_code_out,
    output logic                     sample_out,
    output logic [7:0]               pos_sel_out,
    output logic                     neg_in1_sel_out,
    output logic                     neg_in2_sel_out,
    output logic                     bandgap_sel_out,
    output logic                     ground_sel_out,
    output logic                     diff_mode_out,
    output logic [1:0]               ref_sel_out,
    output logic                     ref_ext_only_out,
    output logic                     ref_supply_out,
    output logic                     ref_internal_out,
    output logic                     busy_out,
    output logic                     complete_flag_out
);
    import acs_pkg::*;

    localparam int DW = $clog2(ADC_DIV);
    localparam logic [DW-1:0] DIV_LAST = DW'(ADC_DIV - 1);

    acs_byte_t      sel_reg;
    acs_byte_t      sel_next;
    acs_byte_t      active_reg;
    acs_byte_t      active_next;
    acs_result_t    result_reg;
    acs_result_t    result_next;
    acs_byte_t      rdata_reg;
    logic           flag_reg;
    logic           flag_next;
    logic           lock_reg;
    logic           lock_next;
    logic [DW-1:0]  div_reg;
    logic           conv_diff_reg;

    wire            tick_w;
    wire            start_w;
    wire            busy_w;
    wire            done_w;
    acs_result_t    raw_w;

    // ****************************************************************
    // Register port decode
    // ****************************************************************
    wire wr_sel_w  = reg_wr_in && (reg_addr_in == `ACS_ADDR_SEL);
    wire wr_ctrl_w = reg_wr_in && (reg_addr_in == `ACS_ADDR_CTRL);
    wire rd_lo_w   = reg_rd_in && (reg_addr_in == `ACS_ADDR_RES_LO);
    wire rd_hi_w   = reg_rd_in && (reg_addr_in == `ACS_ADDR_RES_HI);
    wire align_w   = sel_reg[`ACS_ALIGN_BIT];

    // Alignment is applied at read time so a change shows at once
    wire acs_byte_t lo_byte_w = align_w ? {result_reg[1:0], `ACS_PAD6}
                                        : result_reg[7:0];
    wire acs_byte_t hi_byte_w = align_w ? result_reg[9:2]
                                        : {`ACS_PAD6, result_reg[9:8]};
    wire acs_byte_t ctrl_w    = {`ACS_PAD6, flag_reg, busy_w};

    // Read multiplexer; unmapped offsets read zero
    wire acs_byte_t rd_mux_w =
        (reg_addr_in == `ACS_ADDR_SEL)    ? sel_reg   :
        (reg_addr_in == `ACS_ADDR_RES_LO) ? lo_byte_w :
        (reg_addr_in == `ACS_ADDR_RES_HI) ? hi_byte_w :
        (reg_addr_in == `ACS_ADDR_CTRL)   ? ctrl_w    : `ACS_BYTE_ZERO;

    // ****************************************************************
    // Next-state terms
    // ****************************************************************
    // Every bit is stored as written, reserved reference code included
    assign sel_next    = wr_sel_w ? reg_wdata_in : sel_reg;
    // Selection follows the register while idle and is held while busy
    assign active_next = busy_w ? active_reg : sel_next;
    assign start_w     = wr_ctrl_w && reg_wdata_in[`ACS_CTRL_START_BIT] && !busy_w;
    // Completion sets the flag; a same-cycle one-write clear loses
    assign flag_next   = done_w ||
                         (flag_reg && !(wr_ctrl_w && reg_wdata_in[`ACS_CTRL_FLAG_BIT]));
    // Low-byte read freezes the result until the high byte is read
    assign lock_next   = rd_lo_w ? 1'b1 : (rd_hi_w ? 1'b0 : lock_reg);
    assign result_next = (done_w && !lock_reg) ?
                         acs_format(raw_w, conv_diff_reg) : result_reg;
    assign tick_w      = (div_reg == DIV_LAST);

    // ****************************************************************
    // Registers
    // ****************************************************************
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            sel_reg    <= `ACS_SEL_RST;
            active_reg <= `ACS_SEL_RST;
            result_reg <= '0;
            flag_reg   <= 1'b0;
            lock_reg   <= 1'b0;
        end else begin
            sel_reg    <= sel_next;
            active_reg <= active_next;
            result_reg <= result_next;
            flag_reg   <= flag_next;
            lock_reg   <= lock_next;
        end
    end

    // Read data stand only in the cycle after the strobe
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rdata_reg <= `ACS_BYTE_ZERO;
        end else begin
            rdata_reg <= reg_rd_in ? rd_mux_w : `ACS_BYTE_ZERO;
        end
    end

    // Converter clock enable divider and coding mode of the running conversion
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            div_reg       <= '0;
            conv_diff_reg <= 1'b0;
        end else begin
            div_reg <= tick_w ? '0 : div_reg + 1'b1;
            if (start_w) begin
                conv_diff_reg <= acs_is_diff(active_next[`ACS_CHAN_HI:0]);
            end
        end
    end

    // ****************************************************************
    // Sequencer and channel decoder
    // ****************************************************************
    acs_sar #(
        .RES_BITS (`ACS_RES_BITS)
    ) u_sar (
        .clk_sys_in   (clk_sys_in),
        .rst_n_in     (rst_n_in),
        .tick_in      (tick_w),
        .start_in     (start_w),
        .cmp_in       (cmp_in),
        .busy_out     (busy_w),
        .done_out     (done_w),
        .sample_out   (sample_out),
        .dac_code_out (dac_code_out),
        .raw_out      (raw_w)
    );

    acs_chan_dec u_dec (
        .chan_in     (active_reg[`ACS_CHAN_HI:0]),
        .pos_sel_out (pos_sel_out),
        .neg1_out    (neg_in1_sel_out),
        .neg2_out    (neg_in2_sel_out),
        .bandgap_out (bandgap_sel_out),
        .ground_out  (ground_sel_out),
        .diff_out    (diff_mode_out)
    );

    // Reference switches; the reserved code turns none of them on
    assign ref_sel_out      = active_reg[`ACS_REF_HI:`ACS_REF_LO];
    assign ref_ext_only_out = (ref_sel_out == `ACS_REF_EXT);
    assign ref_supply_out   = (ref_sel_out == `ACS_REF_SUPPLY);
    assign ref_internal_out = (ref_sel_out == `ACS_REF_INTERNAL);

    assign reg_rdata_out     = rdata_reg;
    assign busy_out          = busy_w;
    assign complete_flag_out = flag_reg;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!rst_n_in);

    property p_sel_locked;
        busy_w ##1 busy_w |-> $stable(active_reg);
    endproperty
    a_sel_locked: assert property (p_sel_locked) else $error("selection moved mid-conversion");

    property p_sel_applied;
        done_w |=> (active_reg == $past(sel_next));
    endproperty
    a_sel_applied: assert property (p_sel_applied) else $error("selection not applied at end");

    property p_flag_result;
        done_w && !lock_reg |=>
            flag_reg && (result_reg == acs_format($past(raw_w), $past(conv_diff_reg)));
    endproperty
    a_flag_result: assert property (p_flag_result) else $error("result or flag not updated");

    property p_diff_code;
        done_w && !lock_reg && conv_diff_reg |=> result_reg[9] == !$past(raw_w[9]);
    endproperty
    a_diff_code: assert property (p_diff_code) else $error("differential code not signed");

    property p_single_code;
        done_w && !lock_reg && !conv_diff_reg |=> result_reg == $past(raw_w);
    endproperty
    a_single_code: assert property (p_single_code) else $error("single code not unsigned");

    property p_lock_hold;
        done_w && lock_reg |=> $stable(result_reg);
    endproperty
    a_lock_hold: assert property (p_lock_hold) else $error("result moved while frozen");

    property p_left_read;
        rd_hi_w && align_w |=> reg_rdata_out == $past(result_reg[9:2]);
    endproperty
    a_left_read: assert property (p_left_read) else $error("left aligned high byte wrong");

    property p_right_read;
        rd_lo_w && !align_w |=> reg_rdata_out == $past(result_reg[7:0]);
    endproperty
    a_right_read: assert property (p_right_read) else $error("right aligned low byte wrong");

    property p_readback;
        wr_sel_w ##1 !reg_wr_in ##1 (reg_rd_in && reg_addr_in == `ACS_ADDR_SEL) |=>
            reg_rdata_out == $past(reg_wdata_in, 3);
    endproperty
    a_readback: assert property (p_readback) else $error("select register readback wrong");

    property p_no_input;
        (active_reg[`ACS_CHAN_HI:0] >= `ACS_CH_NONE_FIRST) &&
        (active_reg[`ACS_CHAN_HI:0] <= `ACS_CH_NONE_LAST) |->
            pos_sel_out == '0 && !bandgap_sel_out && !ground_sel_out;
    endproperty
    a_no_input: assert property (p_no_input) else $error("unused code selected an input");

    property p_ref_one;
        ref_sel_out != `ACS_REF_RESERVED |->
            $onehot({ref_ext_only_out, ref_supply_out, ref_internal_out});
    endproperty
    a_ref_one: assert property (p_ref_one) else $error("reference switches not one-hot");

    property p_flag_clear;
        wr_ctrl_w && reg_wdata_in[`ACS_CTRL_FLAG_BIT] && !done_w |=> !flag_reg;
    endproperty
    a_flag_clear: assert property (p_flag_clear) else $error("complete flag not cleared");

    property p_bandgap;
        active_reg[`ACS_CHAN_HI:0] == `ACS_CH_BANDGAP |->
            bandgap_sel_out && !ground_sel_out && pos_sel_out == '0;
    endproperty
    a_bandgap: assert property (p_bandgap) else $error("bandgap code decoded wrong");

    property p_single_in;
        active_reg[`ACS_CHAN_HI:`ACS_CHAN_HI-1] == `ACS_GRP_SINGLE |->
            $onehot(pos_sel_out) && !neg_in1_sel_out && !neg_in2_sel_out && !diff_mode_out;
    endproperty
    a_single_in: assert property (p_single_in) else $error("single code decoded wrong");

    property p_pair_neg1;
        active_reg[`ACS_CHAN_HI:`ACS_CHAN_HI-1] == `ACS_GRP_DIFF_NEG1 |->
            $onehot(pos_sel_out) && neg_in1_sel_out && !neg_in2_sel_out && diff_mode_out;
    endproperty
    a_pair_neg1: assert property (p_pair_neg1) else $error("first pair group wrong");

    property p_right_hi;
        rd_hi_w && !align_w |=> reg_rdata_out == {`ACS_PAD6, $past(result_reg[9:8])};
    endproperty
    a_right_hi: assert property (p_right_hi) else $error("right high byte wrong");

    property p_left_lo;
        rd_lo_w && align_w |=> reg_rdata_out == {$past(result_reg[1:0]), `ACS_PAD6};
    endproperty
    a_left_lo: assert property (p_left_lo) else $error("left low byte wrong");
endmodule : acs_top

/* File: pkg/acs_consts.svh */
/*
 * Named constants of the converter input-select and result-format block:
 * register offsets, field positions, reset values, channel codes and timing.
 * Assumes inclusion by bare name from the package and the design modules.
 */
`ifndef ACS_CONSTS_SVH
`define ACS_CONSTS_SVH

// ****************************************************************
// Register offsets on the plain register port
// ****************************************************************
`define ACS_ADDR_W          3
`define ACS_ADDR_SEL        3'h0
`define ACS_ADDR_RES_LO     3'h1
`define ACS_ADDR_RES_HI     3'h2
`define ACS_ADDR_CTRL       3'h3

// ****************************************************************
// Field positions and reset values
// ****************************************************************
`define ACS_REF_HI          7
`define ACS_REF_LO          6
`define ACS_ALIGN_BIT       5
`define ACS_CHAN_HI         4
`define ACS_SEL_RST         8'h00
`define ACS_CTRL_START_BIT  0
`define ACS_CTRL_FLAG_BIT   1
`define ACS_BYTE_ZERO       8'h00
`define ACS_PAD6            6'h00

// ****************************************************************
// Reference and channel codes
// ****************************************************************
`define ACS_REF_EXT         2'h0
`define ACS_REF_SUPPLY      2'h1
`define ACS_REF_INTERNAL    2'h3
`define ACS_REF_RESERVED    2'h2
`define ACS_CH_NONE_FIRST   5'h08
`define ACS_CH_NONE_LAST    5'h0F
`define ACS_CH_BANDGAP      5'h1E
`define ACS_CH_GROUND       5'h1F
`define ACS_GRP_SINGLE      2'h0
`define ACS_GRP_DIFF_NEG1   2'h2
`define ACS_GRP_DIFF_NEG2   2'h3

// ****************************************************************
// Converter timing: sample length in converter clock ticks, divider in system clocks per tick
// ****************************************************************
`define ACS_RES_BITS        10
`define ACS_SAMPLE_TICKS    2
`define ACS_ADC_DIV         8

`endif

/* File: pkg/acs_pkg.sv */
/*
 * Types and shared helpers of the converter input-select block.
 * Assumes acs_consts.svh is on the include path.
 */
package acs_pkg;
    `include "acs_consts.svh"

    typedef logic [7:0]                 acs_byte_t;
    typedef logic [`ACS_RES_BITS-1:0]   acs_result_t;
    typedef logic [`ACS_CHAN_HI:0]      acs_chan_t;
    typedef logic [`ACS_ADDR_W-1:0]     acs_addr_t;
    typedef enum logic [1:0] {ACS_ST_IDLE, ACS_ST_SAMPLE, ACS_ST_CONVERT} acs_state_t;

    // True for the differential pair codes
    function automatic logic acs_is_diff(input acs_chan_t ch);
        return ch[`ACS_CHAN_HI] && (ch < `ACS_CH_BANDGAP);
    endfunction : acs_is_diff

    // Offset binary from the array becomes two's complement for pairs
    function automatic acs_result_t acs_format(input acs_result_t raw, input logic diff);
        acs_result_t res;
        res = raw;
        if (diff) begin
            res[`ACS_RES_BITS-1] = ~raw[`ACS_RES_BITS-1];
        end
        return res;
    endfunction : acs_format
endpackage : acs_pkg

/* File: hw/acs_sar.sv */
/*
 * Successive-approximation sequencer: sampling phase, then one trial bit
 * per converter tick from the top bit down.
 * Assumes an external DAC and comparator; cmp_in is high when the input
 * is at or above the level set by dac_code_out.
 */
`timescale 1ns/1ps
`include "acs_consts.svh"
module acs_sar #(
    parameter int RES_BITS = `ACS_RES_BITS
) (
    input  wire logic                clk_sys_in,
    input  wire logic                rst_n_in,
    input  wire logic                tick_in,
    input  wire logic                start_in,
    input  wire logic                cmp_in,
    output logic                     busy_out,
    output logic                     done_out,
    output logic                     sample_out,
    output logic [RES_BITS-1:0]      dac_code_out,
    output logic [RES_BITS-1:0]      raw_out
);
    import acs_pkg::*;

    localparam int IW = $clog2(RES_BITS);
    localparam logic [IW-1:0] TOP_BIT = IW'(RES_BITS - 1);
    localparam logic [IW-1:0] LAST_SAMPLE = IW'(`ACS_SAMPLE_TICKS - 1);

    acs_state_t             state_reg;
    logic [IW-1:0]          idx_reg;
    logic [RES_BITS-1:0]    code_reg;
    logic [RES_BITS-1:0]    raw_reg;
    logic                   done_reg;

    // ****************************************************************
    // Sequencer
    // ****************************************************************
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state_reg <= ACS_ST_IDLE;
            idx_reg   <= '0;
            code_reg  <= '0;
            raw_reg   <= '0;
            done_reg  <= 1'b0;
        end else begin
            done_reg <= 1'b0;
            case (state_reg)
                ACS_ST_IDLE: begin
                    if (start_in) begin
                        state_reg <= ACS_ST_SAMPLE;
                        idx_reg   <= '0;
                        code_reg  <= '0;
                    end
                end
                ACS_ST_SAMPLE: begin
                    if (tick_in && idx_reg == LAST_SAMPLE) begin
                        state_reg         <= ACS_ST_CONVERT;
                        idx_reg           <= TOP_BIT;
                        code_reg[TOP_BIT] <= 1'b1;
                    end else if (tick_in) begin
                        idx_reg <= idx_reg + 1'b1;
                    end
                end
                ACS_ST_CONVERT: begin
                    if (tick_in) begin
                        code_reg[idx_reg] <= cmp_in;
                        if (idx_reg == '0) begin
                            state_reg <= ACS_ST_IDLE;
                            raw_reg   <= {code_reg[RES_BITS-1:1], cmp_in};
                            done_reg  <= 1'b1;
                        end else begin
                            code_reg[idx_reg - 1'b1] <= 1'b1;
                            idx_reg <= idx_reg - 1'b1;
                        end
                    end
                end
                default: state_reg <= ACS_ST_IDLE;
            endcase
        end
    end

    // Status and array drive
    assign busy_out     = (state_reg != ACS_ST_IDLE);
    assign sample_out   = (state_reg == ACS_ST_SAMPLE);
    assign done_out     = done_reg;
    assign dac_code_out = code_reg;
    assign raw_out      = raw_reg;
endmodule : acs_sar

/* File: hw/acs_chan_dec.sv */
/*
 * Channel field decoder: turns the five-bit selection into switch enables
 * for the positive inputs, the two negative inputs, bandgap and ground.
 * Assumes the analog switches are active high.
 */
`timescale 1ns/1ps
`include "acs_consts.svh"
module acs_chan_dec (
    input  wire acs_pkg::acs_chan_t  chan_in,
    output logic [7:0]               pos_sel_out,
    output logic                     neg1_out,
    output logic                     neg2_out,
    output logic                     bandgap_out,
    output logic                     ground_out,
    output logic                     diff_out
);
    import acs_pkg::*;

    wire [1:0] grp_w     = chan_in[`ACS_CHAN_HI:`ACS_CHAN_HI-1];
    wire       single_w  = (grp_w == `ACS_GRP_SINGLE);
    wire       diff1_w   = (grp_w == `ACS_GRP_DIFF_NEG1);
    wire       diff2_w   = acs_is_diff(chan_in) && (grp_w == `ACS_GRP_DIFF_NEG2);
    wire       pos_on_w  = single_w || diff1_w || diff2_w;

    // Codes 01000 to 01111 fall through every term and select nothing
    assign pos_sel_out = pos_on_w ? (8'h01 << chan_in[2:0]) : `ACS_BYTE_ZERO;
    assign neg1_out    = diff1_w;
    assign neg2_out    = diff2_w;
    assign bandgap_out = (chan_in == `ACS_CH_BANDGAP);
    assign ground_out  = (chan_in == `ACS_CH_GROUND);
    assign diff_out    = acs_is_diff(chan_in);
endmodule : acs_chan_dec

/* File: test/testbench.sv */
/*
 * Self-checking bench for the converter input-select and result-format block.
 * Assumes acs_pkg is compiled first; the comparator is modelled from a target code.
 */
`timescale 1ns/1ps
`include "acs_consts.svh"
module testbench;
    import acs_pkg::*;
    localparam int DIV = 2;
    logic               clk_sys_in;
    logic               rst_n_in;
    acs_addr_t          reg_addr_in;
    acs_byte_t          reg_wdata_in;
    logic               reg_wr_in;
    logic               reg_rd_in;
    acs_byte_t          reg_rdata_out;
    acs_result_t        dac_code_out;
    logic               sample_out;
    logic [7:0]         pos_sel_out;
    logic               neg_in1_sel_out, neg_in2_sel_out, bandgap_sel_out, ground_sel_out;
    logic               diff_mode_out, ref_ext_only_out, ref_supply_out, ref_internal_out;
    logic [1:0]         ref_sel_out;
    logic               busy_out, complete_flag_out;
    int                 target, last_res, n_fail, checks_done, cycles, seed;
    wire                cmp_in = (dac_code_out <= target[9:0]);
    wire [12:0]         dec_seen = {pos_sel_out, neg_in1_sel_out, neg_in2_sel_out,
                                    bandgap_sel_out, ground_sel_out, diff_mode_out};

    acs_top #(.ADC_DIV(DIV)) i_dut (
        .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .reg_addr_in(reg_addr_in),
        .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
        .reg_rdata_out(reg_rdata_out), .cmp_in(cmp_in), .dac_code_out(dac_code_out),
        .sample_out(sample_out), .pos_sel_out(pos_sel_out),
        .neg_in1_sel_out(neg_in1_sel_out), .neg_in2_sel_out(neg_in2_sel_out),
        .bandgap_sel_out(bandgap_sel_out), .ground_sel_out(ground_sel_out),
        .diff_mode_out(diff_mode_out), .ref_sel_out(ref_sel_out),
        .ref_ext_only_out(ref_ext_only_out), .ref_supply_out(ref_supply_out),
        .ref_internal_out(ref_internal_out), .busy_out(busy_out),
        .complete_flag_out(complete_flag_out));

    // ****************************************************************
    // Clock and hang guard
    // ****************************************************************
    always #12.5 clk_sys_in = ~clk_sys_in;
    always @(posedge clk_sys_in) begin
        cycles++;
        if (cycles >= 5000) begin
            n_fail++;
            test_done();
        end
    end

    // ****************************************************************
    // Reference model and checking helpers
    // ****************************************************************
    function automatic logic [12:0] dec_model(input int c);
        logic [12:0] r;
        r = 13'h0000;
        if (c < 8) r[12:5] = 8'h01 << c;
        else if (c >= 16 && c < 24) r = {8'h01 << (c - 16), 5'h11};
        else if (c >= 24 && c < 30) r = {8'h01 << (c - 24), 5'h09};
        else if (c == 30) r[2] = 1'b1;
        else if (c == 31) r[1] = 1'b1;
        return r;
    endfunction : dec_model

    function automatic logic [15:0] fmt(input int r, input logic left);
        logic [9:0] v;
        v = r[9:0];
        return left ? {v, 6'h00} : {6'h00, v};
    endfunction : fmt

    task automatic chk(input string n, input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            $display("Error %s expected %h seen %h", n, exp, seen);
            n_fail++;
        end
    endtask : chk

    task automatic test_done();
        if (n_fail == 0 && checks_done > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : test_done

    // Register port cycles: one-cycle strobes, read data the cycle after
    task automatic wr(input acs_addr_t a, input acs_byte_t d);
        @(posedge clk_sys_in);
        reg_addr_in  <= a;
        reg_wdata_in <= d;
        reg_wr_in    <= 1'b1;
        @(posedge clk_sys_in);
        reg_wr_in    <= 1'b0;
    endtask : wr

    task automatic rd(input acs_addr_t a, output acs_byte_t d);
        @(posedge clk_sys_in);
        reg_addr_in <= a;
        reg_rd_in   <= 1'b1;
        @(posedge clk_sys_in);
        reg_rd_in   <= 1'b0;
        #1 d = reg_rdata_out;
    endtask : rd

    // Active selection against the decode model; reserved reference is a don't-care
    task automatic check_sel(input acs_byte_t s);
        chk("decode", {3'h0, dec_seen}, {3'h0, dec_model(s[4:0])});
        chk("ref_field", {14'h0000, ref_sel_out}, {14'h0000, s[7:6]});
        if (s[7:6] != 2'h2) chk("ref_dec", {ref_ext_only_out, ref_supply_out, ref_internal_out},
            {s[7:6] == 2'h0, s[7:6] == 2'h1, s[7:6] == 2'h3});
    endtask : check_sel

    // One conversion; s2 is written mid-run, frz expects the frozen old result
    task automatic conv(input acs_byte_t s, input int tgt, input acs_byte_t s2, input bit frz);
        acs_byte_t lo, hi;
        int        n;
        int        res;
        target <= tgt;
        wr(`ACS_ADDR_SEL, s);
        wr(`ACS_ADDR_CTRL, 8'h01);
        res = (s[4] && s[4:0] < 5'h1E) ? (tgt ^ 32'h200) : tgt;
        #1 chk("busy", {14'h0000, sample_out, busy_out}, 16'h0003);
        if (s2 != s) begin
            wr(`ACS_ADDR_SEL, s2);
            rd(`ACS_ADDR_RES_HI, hi);
            chk("hi_live", {8'h00, hi}, fmt(last_res, s2[5]) >> 8);
            check_sel(s);
        end
        n = 0;
        while (busy_out !== 1'b0 && n < 200) begin
            @(posedge clk_sys_in);
            #1 n++;
        end
        chk("done_wait", {15'h0000, busy_out}, 16'h0000);
        repeat (2) @(posedge clk_sys_in);
        #1 check_sel(s2);
        chk("flag_pin", {15'h0000, complete_flag_out}, 16'h0001);
        rd(`ACS_ADDR_CTRL, lo);
        chk("flag", {8'h00, lo}, 16'h0002);
        wr(`ACS_ADDR_CTRL, 8'h02);
        #1 chk("flag_clr", {15'h0000, complete_flag_out}, 16'h0000);
        if (!frz) last_res = res;
        rd(`ACS_ADDR_RES_LO, lo);
        rd(`ACS_ADDR_RES_HI, hi);
        chk("result", {hi, lo}, fmt(last_res, s2[5]));
    endtask : conv

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        acs_byte_t b;
        acs_byte_t s;
        static acs_byte_t sels [6] = '{8'h00, 8'h00, 8'h50, 8'h78, 8'hFB, 8'h5F};
        static int        tgts [6] = '{0, 32'h3FF, 32'h3FF, 0, 32'h1A3, 32'h155};
        clk_sys_in = 1'b0;
        rst_n_in = 1'b0;
        reg_addr_in = 3'h0;
        reg_wdata_in = 8'h00;
        reg_wr_in = 1'b0;
        reg_rd_in = 1'b0;
        target = 0;
        last_res = 0;
        seed = 32'hB73461B1;
        repeat (12) @(posedge clk_sys_in);
        rst_n_in <= 1'b1;
        rd(`ACS_ADDR_SEL, b);
        chk("sel_reset", {8'h00, b}, 16'h0000);
        check_sel(8'h00);
        rd(3'h5, b);
        chk("unmapped", {8'h00, b}, 16'h0000);
        for (int i = 0; i < 36; i++) begin
            s = (i < 32) ? (($random(seed) & 8'hE0) | i) : (((i - 32) << 6) | 8'h1E);
            wr(`ACS_ADDR_SEL, s);
            rd(`ACS_ADDR_SEL, b);
            chk("sel_rw", {8'h00, b}, {8'h00, s});
            check_sel(s);
        end
        for (int i = 0; i < 6; i++) conv(sels[i], tgts[i], sels[i], 1'b0);
        conv(8'h00, 32'h155, 8'hF0, 1'b0);
        for (int i = 0; i < 6; i++) begin
            s = $random(seed);
            conv(s, $random(seed) & 32'h3FF, s, 1'b0);
        end
        rd(`ACS_ADDR_RES_LO, b);
        conv(8'h01, 32'h0AA, 8'h01, 1'b1);
        conv(8'h21, 32'h0AA, 8'h21, 1'b0);
        test_done();
    end
endmodule : testbench
